// ---- pkg/mps_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH

`define MPS_OFS_CTRL        12'h000
`define MPS_OFS_HOLD        12'h004
`define MPS_OFS_TIMEOUT     12'h008
`define MPS_OFS_STATUS      12'h00c

`define MPS_CTRL_MODE_BIT   0
`define MPS_CTRL_LEAD_LSB   8
`define MPS_CTRL_ONES_LSB   16
`define MPS_CTRL_TENS_LSB   24

`define MPS_RST_MODE        1'b0
`define MPS_RST_LEAD        8'h40
`define MPS_RST_TENS        8'h30
`define MPS_RST_ONES        8'h31
`define MPS_RST_HOLD        16'h0000
`define MPS_RST_TIMEOUT     16'h001e

`define MPS_LEAD_AT         8'h40
`define MPS_LEAD_HASH       8'h23
`define MPS_LEAD_DOLLAR     8'h24
`define MPS_LEAD_PERCENT    8'h25
`define MPS_LEAD_AMP        8'h26

`define MPS_CHR_ZERO        8'h30
`define MPS_CHR_NINE        8'h39
`define MPS_CHR_CR          8'h0d

`define MPS_CLK_HZ          100000000
`define MPS_SECOND_S        1
`define MPS_CYC_PER_SEC     (`MPS_CLK_HZ * `MPS_SECOND_S)

`endif

// ---- pkg/mps_pkg.sv ----
// Types shared by the port switch design
package mps_pkg;

	typedef enum logic [3:0] {
		MPS_HUNT = 4'b0001,
		MPS_TENS = 4'b0010,
		MPS_ONES = 4'b0100,
		MPS_OPEN = 4'b1000
	} mps_state_t;

	typedef logic [7:0] mps_char_t;

endpackage : mps_pkg

// ---- hw/mps_fifo.sv ----
// Small valid/ready buffer with registered ready and valid
`timescale 1ns/10ps

module mps_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             in_ready_reg;
	logic             out_valid_reg;
	logic             push;
	logic             pop;

	assign push      = in_valid & in_ready_reg;
	assign pop       = out_valid_reg & out_ready;
	assign in_ready  = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data  = mem_reg[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + CW'(1);
		end else if (pop && !push) begin
			count_next = count_reg - CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			in_ready_reg  <= 1'b1;
			out_valid_reg <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + PW'(1);
			end
			count_reg     <= count_next;
			// Registered flags keep the ports free of combinational paths
			in_ready_reg  <= (count_next != FULL);
			out_valid_reg <= (count_next != '0);
		end
	end

endmodule : mps_fifo

// ---- hw/mps_port_switch.sv ----
// Address-gated session logic for a port on a shared serial line
`timescale 1ns/10ps
`include "mps_map.svh"

module mps_port_switch #(
	parameter int          ADDR_W      = 12,
	parameter int          FIFO_DEPTH  = 2,
	parameter int unsigned CYC_PER_SEC = `MPS_CYC_PER_SEC
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Received characters from the line
	input  wire logic              rx_valid,
	input  wire logic [7:0]        rx_data,
	output logic                   rx_ready,
	// Characters to the command interpreter
	output logic                   cmd_valid,
	output logic [7:0]             cmd_data,
	input  wire logic              cmd_ready,
	// Messages from the command interpreter
	input  wire logic              msg_valid,
	input  wire logic [7:0]        msg_data,
	output logic                   msg_ready,
	// Characters to the line transmitter
	output logic                   tx_valid,
	output logic [7:0]             tx_data,
	input  wire logic              tx_ready,
	// Line control
	output logic                   rts,
	output logic                   echo_enable,
	output logic                   session_open
);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned SEC_MAX    = CYC_PER_SEC - 1;
	localparam mps_pkg::mps_char_t END_CMD [4] = '{8'h51, 8'h55, 8'h49, 8'h54};

	////////////////////////////////////////////////////////////////////////
	// Register bus

	logic               awready_reg, wready_reg, bvalid_reg;
	logic               arready_reg, rvalid_reg;
	logic [1:0]         bresp_reg, rresp_reg;
	logic [31:0]        rdata_reg;
	logic               aw_got_reg, w_got_reg;
	logic [ADDR_W-1:0]  waddr_reg;
	logic [31:0]        wdata_reg;
	logic [3:0]         wstrb_reg;
	logic               port_mode_reg;
	mps_pkg::mps_char_t lead_reg, tens_reg, ones_reg;
	logic [15:0]        hold_reg, timeout_reg;
	logic [31:0]        ctrl_word, ctrl_merged, wmask;
	logic               do_write;
	mps_pkg::mps_state_t state_reg;
	logic               rts_reg, echo_reg, open_reg, tx_go_reg;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	assign do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
	assign ctrl_word = {tens_reg, ones_reg, lead_reg, 7'h00, port_mode_reg};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
		end
	endgenerate

	assign ctrl_merged = (ctrl_word & ~wmask) | (wdata_reg & wmask);

	function automatic logic lead_ok(input mps_pkg::mps_char_t c);
		lead_ok = (c == `MPS_LEAD_AT) || (c == `MPS_LEAD_HASH) ||
			(c == `MPS_LEAD_DOLLAR) || (c == `MPS_LEAD_PERCENT) ||
			(c == `MPS_LEAD_AMP);
	endfunction : lead_ok

	function automatic logic digit_ok(input mps_pkg::mps_char_t c);
		digit_ok = (c >= `MPS_CHR_ZERO) && (c <= `MPS_CHR_NINE);
	endfunction : digit_ok

	// Write channels are taken in either order; response follows both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			waddr_reg   <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_got_reg  <= 1'b1;
				awready_reg <= 1'b0;
				waddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_got_reg  <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= (waddr_reg == ADDR_W'(`MPS_OFS_CTRL) ||
					waddr_reg == ADDR_W'(`MPS_OFS_HOLD) ||
					waddr_reg == ADDR_W'(`MPS_OFS_TIMEOUT)) ?
					RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Illegal field values are dropped so the port never holds a bad setting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_mode_reg <= `MPS_RST_MODE;
			lead_reg    <= `MPS_RST_LEAD;
			tens_reg    <= `MPS_RST_TENS;
			ones_reg    <= `MPS_RST_ONES;
			hold_reg    <= `MPS_RST_HOLD;
			timeout_reg <= `MPS_RST_TIMEOUT;
		end else if (do_write) begin
			if (waddr_reg == ADDR_W'(`MPS_OFS_CTRL)) begin
				port_mode_reg <= ctrl_merged[`MPS_CTRL_MODE_BIT];
				if (lead_ok(ctrl_merged[`MPS_CTRL_LEAD_LSB +: 8])) begin
					lead_reg <= ctrl_merged[`MPS_CTRL_LEAD_LSB +: 8];
				end
				if (digit_ok(ctrl_merged[`MPS_CTRL_TENS_LSB +: 8]) &&
					digit_ok(ctrl_merged[`MPS_CTRL_ONES_LSB +: 8]) &&
					ctrl_merged[`MPS_CTRL_ONES_LSB +: 16] != 16'h3030) begin
					tens_reg <= ctrl_merged[`MPS_CTRL_TENS_LSB +: 8];
					ones_reg <= ctrl_merged[`MPS_CTRL_ONES_LSB +: 8];
				end
			end
			if (waddr_reg == ADDR_W'(`MPS_OFS_HOLD)) begin
				hold_reg <= (wdata_reg[15:0] & wmask[15:0]) |
					(hold_reg & ~wmask[15:0]);
			end
			if (waddr_reg == ADDR_W'(`MPS_OFS_TIMEOUT)) begin
				timeout_reg <= (wdata_reg[15:0] & wmask[15:0]) |
					(timeout_reg & ~wmask[15:0]);
			end
		end
	end

	// Reads answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rresp_reg   <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_W'(`MPS_OFS_CTRL):    rdata_reg <= ctrl_word;
				ADDR_W'(`MPS_OFS_HOLD):    rdata_reg <= {16'h0000, hold_reg};
				ADDR_W'(`MPS_OFS_TIMEOUT): rdata_reg <= {16'h0000, timeout_reg};
				ADDR_W'(`MPS_OFS_STATUS):  rdata_reg <= {24'h00_0000, state_reg,
					tx_go_reg, echo_reg, rts_reg, open_reg};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address hunt and session state

	logic       rx_take, rx_ready_w, cmd_in_ready;
	logic       end_seen, timed_out, shared_mode;
	logic [2:0] end_idx_reg;
	mps_pkg::mps_state_t state_next;

	assign shared_mode = port_mode_reg;
	assign rx_ready_w  = cmd_in_ready;
	assign rx_take     = rx_valid & rx_ready_w;
	assign end_seen    = rx_take && (end_idx_reg == 3'h4) &&
		(rx_data == `MPS_CHR_CR);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			mps_pkg::MPS_HUNT: begin
				if (rx_take && rx_data == lead_reg) begin
					state_next = mps_pkg::MPS_TENS;
				end
			end
			mps_pkg::MPS_TENS: begin
				if (rx_take) begin
					// A repeated lead restarts the address rather than losing it
					state_next = (rx_data == tens_reg) ? mps_pkg::MPS_ONES :
						(rx_data == lead_reg) ? mps_pkg::MPS_TENS :
						mps_pkg::MPS_HUNT;
				end
			end
			mps_pkg::MPS_ONES: begin
				if (rx_take) begin
					state_next = (rx_data == ones_reg) ? mps_pkg::MPS_OPEN :
						(rx_data == lead_reg) ? mps_pkg::MPS_TENS :
						mps_pkg::MPS_HUNT;
				end
			end
			mps_pkg::MPS_OPEN: begin
				if (end_seen || timed_out) begin
					state_next = mps_pkg::MPS_HUNT;
				end
			end
			default: state_next = mps_pkg::MPS_HUNT;
		endcase
		if (!shared_mode) begin
			state_next = mps_pkg::MPS_HUNT;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= mps_pkg::MPS_HUNT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Session-end word is the four letters followed by carriage return
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg != mps_pkg::MPS_OPEN) begin
			end_idx_reg <= 3'h0;
		end else if (rx_take) begin
			if (end_idx_reg < 3'h4 && rx_data == END_CMD[end_idx_reg[1:0]]) begin
				end_idx_reg <= end_idx_reg + 3'h1;
			end else begin
				end_idx_reg <= (rx_data == END_CMD[0]) ? 3'h1 : 3'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Second timers for hold-off and inactivity

	logic [31:0] hold_cyc_reg, idle_cyc_reg;
	logic [15:0] hold_sec_reg, idle_sec_reg;
	logic        opening;

	assign opening   = (state_next == mps_pkg::MPS_OPEN) &&
		(state_reg != mps_pkg::MPS_OPEN);
	assign timed_out = (timeout_reg != 16'h0000) &&
		(idle_sec_reg >= timeout_reg);

	// Timeout of zero disables inactivity close
	always_ff @(posedge aclk) begin
		if (!aresetn || opening || rx_take) begin
			idle_cyc_reg <= 32'h0000_0000;
			idle_sec_reg <= 16'h0000;
		end else if (state_reg == mps_pkg::MPS_OPEN) begin
			if (idle_cyc_reg == SEC_MAX) begin
				idle_cyc_reg <= 32'h0000_0000;
				if (idle_sec_reg != 16'hffff) begin
					idle_sec_reg <= idle_sec_reg + 16'h0001;
				end
			end else begin
				idle_cyc_reg <= idle_cyc_reg + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || opening) begin
			hold_cyc_reg <= 32'h0000_0000;
			hold_sec_reg <= 16'h0000;
		end else if (rts_reg && !tx_go_reg) begin
			if (hold_cyc_reg == SEC_MAX) begin
				hold_cyc_reg <= 32'h0000_0000;
				hold_sec_reg <= hold_sec_reg + 16'h0001;
			end else begin
				hold_cyc_reg <= hold_cyc_reg + 32'h0000_0001;
			end
		end
	end

	// Native protocol keeps the port always live
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			open_reg  <= 1'b0;
			rts_reg   <= 1'b0;
			echo_reg  <= 1'b0;
			tx_go_reg <= 1'b0;
		end else if (!shared_mode) begin
			open_reg  <= 1'b0;
			rts_reg   <= 1'b1;
			echo_reg  <= 1'b1;
			tx_go_reg <= 1'b1;
		end else if (state_next == mps_pkg::MPS_OPEN) begin
			open_reg  <= 1'b1;
			rts_reg   <= 1'b1;
			echo_reg  <= 1'b1;
			tx_go_reg <= !opening && (tx_go_reg ||
				hold_sec_reg >= hold_reg);
		end else begin
			open_reg  <= 1'b0;
			rts_reg   <= 1'b0;
			echo_reg  <= 1'b0;
			tx_go_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data paths through the buffers

	logic cmd_push, msg_push, tx_fifo_valid;

	// Only an open session or native mode reaches the command set
	assign cmd_push = rx_valid && (!shared_mode ||
		state_reg == mps_pkg::MPS_OPEN);
	assign msg_push = msg_valid && echo_reg;

	mps_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_cmd_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (cmd_push),
		.in_data   (rx_data),
		.in_ready  (cmd_in_ready),
		.out_valid (cmd_valid),
		.out_data  (cmd_data),
		.out_ready (cmd_ready)
	);

	// Messages wait in the buffer until the hold-off has run out
	mps_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (msg_push),
		.in_data   (msg_data),
		.in_ready  (msg_ready),
		.out_valid (tx_fifo_valid),
		.out_data  (tx_data),
		.out_ready (tx_ready && tx_go_reg)
	);

	// Valid is hidden during hold-off so a ready line never sees a refused word
	assign tx_valid     = tx_fifo_valid & tx_go_reg;
	assign rx_ready     = rx_ready_w;
	assign rts          = rts_reg;
	assign echo_enable  = echo_reg;
	assign session_open = open_reg;

endmodule : mps_port_switch

// ---- test/mps_port_switch_assertions.sv ----
// Concurrent checks on the port switch top-level ports
`timescale 1ns/10ps

module mps_port_switch_assertions #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Streams
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_ready,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_data,
	input wire logic        cmd_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_ready,
	// Line control
	input wire logic        rts,
	input wire logic        echo_enable,
	input wire logic        session_open
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	cmd_hold_a: assert property (cmd_valid && !cmd_ready
		|=> cmd_valid && $stable(cmd_data)) else $error("cmd lost");
	tx_hold_a: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data)) else $error("tx lost");
	open_flags_a: assert property ($rose(session_open)
		|-> rts && echo_enable) else $error("open without echo");
	open_cause_a: assert property ($rose(session_open)
		|-> $past(rx_valid && rx_ready)) else $error("open uncaused");
	session_end_command_close_a: assert property ($fell(session_open) &&
		$past(rx_valid && rx_ready) |-> $past(rx_data) == 8'h0d)
		else $error("close on wrong char");
endmodule : mps_port_switch_assertions

bind mps_port_switch mps_port_switch_assertions #(.ADDR_W(ADDR_W)) u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .rx_valid, .rx_data, .rx_ready, .cmd_valid,
	.cmd_data, .cmd_ready, .tx_valid, .tx_data, .tx_ready, .rts,
	.echo_enable, .session_open
);

// ---- test/mps_line_model.sv ----
// Remote master on the shared line: sends characters, takes replies
`timescale 1ns/10ps

module mps_line_model (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Line towards the port
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input wire logic        rx_ready,
	// Line from the port
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	output logic            tx_ready,
	// Stall the reply side (tx_ready) every other cycle
	input wire logic        slow
);
	logic [7:0] q[$];
	int         tx_cnt;
	logic [7:0] tx_last;

	task automatic send(input logic [7:0] c);
		q.push_back(c);
	endtask : send

	// Idle line inverts its data every cycle, so the last character shows again every other cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end else if (!rx_valid || rx_ready) begin
			if (q.size() > 0) begin
				rx_valid <= 1'b1;
				rx_data  <= q.pop_front();
			end else begin
				rx_valid <= 1'b0;
				rx_data  <= ~rx_data;
			end
		end
	end

	always @(posedge aclk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			tx_cnt  <= tx_cnt + 1;
			tx_last <= tx_data;
		end
	end

	initial begin
		tx_cnt   = 0;
		tx_ready = 1'b0;
	end
endmodule : mps_line_model

// ---- test/mps_port_switch_tb_top.sv ----
// Bench for the shared-line port switch
`timescale 1ns/10ps

module mps_port_switch_tb_top;
	localparam int CPS = 20;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid, rx_ready;
	logic cmd_valid, cmd_ready, msg_valid, msg_ready, tx_valid, tx_ready;
	logic rts, echo_enable, session_open, slow;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  rx_data, cmd_data, msg_data, tx_data;
	logic [7:0]  got[$];
	logic [7:0]  leads[5] = '{8'h40, 8'h23, 8'h24, 8'h25, 8'h26};
	int fails, check_count, open_cyc;

	mps_port_switch #(.CYC_PER_SEC(CPS)) dut (.*);
	mps_line_model u_line (.aclk, .aresetn, .rx_valid, .rx_data,
		.rx_ready, .tx_valid, .tx_data, .tx_ready, .slow);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		open_cyc <= session_open ? open_cyc + 1 : 0;
		if (cmd_valid && cmd_ready)
			got.push_back(cmd_data);
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
		@(posedge aclk);
	endtask : axw

	task automatic axr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
		@(posedge aclk);
	endtask : axr

	task automatic say(input string s);
		foreach (s[i]) u_line.send(s[i]);
		while (u_line.q.size() != 0 || rx_valid)
			@(posedge aclk);
		repeat (3) @(posedge aclk);
	endtask : say

	task automatic msg(input logic [7:0] c);
		msg_valid <= 1'b1;
		msg_data <= c;
		do begin
			@(posedge aclk);
		end while (!msg_ready);
		msg_valid <= 1'b0;
		@(posedge aclk);
	endtask : msg

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		close_out;
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, cmd_ready, msg_valid, slow} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		msg_data = 8'h00;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(12'h000, 32'h3031_4000, 2'h0);
		axr(12'h004, 32'h0, 2'h0);
		axr(12'h008, 32'h1e, 2'h0);
		axr(12'h010, 32'h0, 2'h2);
		axw(12'h00c, 32'h1, 2'h2);
		foreach (leads[i]) begin
			axw(12'h000, {16'h3031, leads[i], 8'h00}, 2'h0);
			axr(12'h000, {16'h3031, leads[i], 8'h00}, 2'h0);
		end
		axw(12'h000, 32'h3031_4100, 2'h0);
		axr(12'h000, 32'h3031_2600, 2'h0);
		axw(12'h000, 32'h3030_2600, 2'h0);
		axr(12'h000, 32'h3031_2600, 2'h0);
		axw(12'h000, 32'h3939_2600, 2'h0);
		axr(12'h000, 32'h3939_2600, 2'h0);
		// Native mode, receiver stalled until the buffer refuses
		u_line.send(8'h61);
		u_line.send(8'h62);
		u_line.send(8'h63);
		repeat (10) @(posedge aclk);
		chk(rx_ready, 1'b0);
		chk(session_open, 1'b0);
		cmd_ready <= 1'b1;
		say("");
		chk({got.size(), got[0], got[2]}, {32'd3, 8'h61, 8'h63});
		got.delete();
		// Shared-line mode: station 42, lead #, hold one second
		axw(12'h008, 32'h0, 2'h0);
		axw(12'h004, 32'h1, 2'h0);
		axw(12'h000, 32'h3432_2301, 2'h0);
		chk(echo_enable, 1'b0);
		msg(8'h7a);
		chk({tx_valid, msg_ready}, 2'h1);
		say("#43x#4");
		chk({session_open, rts, u_line.tx_cnt}, 0);
		slow <= 1'b1;
		say("2");
		chk({session_open, rts, echo_enable}, 3'h7);
		chk(got.size(), 0);
		axr(12'h00c, 32'h87, 2'h0);
		msg(8'h50);
		while (u_line.tx_cnt == 0)
			@(posedge aclk);
		chk(open_cyc >= CPS, 1'b1);
		chk(u_line.tx_last, 8'h50);
		// Prompt seen, so commands may follow
		say("AQUIT");
		say("\015");
		chk(session_open, 1'b0);
		say("B");
		chk({got.size(), got[0], got[5]}, {32'd6, 8'h41, 8'h0d});
		// Two-second inactivity close
		axw(12'h008, 32'h2, 2'h0);
		say("#42");
		repeat (25) @(posedge aclk);
		chk(session_open, 1'b1);
		repeat (40) @(posedge aclk);
		chk(session_open, 1'b0);
		close_out;
	end
endmodule : mps_port_switch_tb_top
